// ### dbs_port.sv
// Pin-level command and data port of the burst-of-two double-rate RAM
`timescale 1ns/10ps
`default_nettype none
module dbs_port
    import dbs_pkg::*;
#(
    parameter int DW = 36,
    parameter int AW = 19
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 k_clk,
    input  wire logic                 load_strobe_n,
    input  wire logic                 access_dir_read,
    input  wire logic [AW-1:0]        addr_i,
    input  wire logic [DW-1:0]        dq_i,
    output logic      [DW-1:0]        dq_o,
    output logic      [DW-1:0]        dq_oe_n,
    input  wire logic [NIB_SEL_W-1:0] nibble_write_select_n,
    input  wire logic [SEL_MAX_W-1:0] byte_write_select_n,
    output logic                      read_valid_flag,
    output logic      [ECHO_W-1:0]    echo_timing_pair
);
    localparam int SW = (DW == 8) ? NIB_SEL_W : DW / LANE9_W;
    localparam int LW = (DW == 8) ? NIB_W : LANE9_W;

    // Unused select bits read as masked, so they never write
    function automatic logic [SEL_MAX_W-1:0] pad_sel(input logic [SW-1:0] s);
        pad_sel         = '1;
        pad_sel[SW-1:0] = s;
    endfunction

    if (!(DW == 8 || DW == 9 || DW == 18 || DW == 36) || AW < 1 || AW > ADDR_MAX_W) begin : g_bad
        $error("dbs_port: unsupported DW or AW");
    end

    // Lane selects of whichever variant is built
    logic [SEL_MAX_W-1:0] sel_n;
    assign sel_n = (DW == 8) ? {{(SEL_MAX_W-NIB_SEL_W){1'b1}}, nibble_write_select_n}
                             : byte_write_select_n;

    // Link-side reset, carried over from the system clock
    logic [1:0] rst_k_s;
    logic       rst_k_q;
    always_ff @(posedge k_clk) begin
        rst_k_s <= {rst_k_s[0], reset};
        rst_k_q <= rst_k_s[1];
    end

    // Command capture on the positive edge
    logic              wr_pend_q;
    logic [AW-1:0]     wr_addr_q;
    logic              cmd_new;
    logic              cmd_tog_q;
    dbs_cmd_type       cmd_q;
    logic [DW-1:0]     wd0_n_q;
    logic [SW-1:0]     ws0_n_q;

    assign cmd_new = !load_strobe_n;

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= cmd_new && !access_dir_read;
        end
    end

    // Address only taken from a selected cycle
    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            wr_addr_q <= '0;
        end else if (cmd_new) begin
            wr_addr_q <= addr_i;
        end
    end

    // First write word and selects on the negative-clock edge
    always_ff @(negedge k_clk) begin
        if (rst_k_q) begin
            wd0_n_q <= '0;
            ws0_n_q <= '1;
        end else if (wr_pend_q) begin
            wd0_n_q <= dq_i;
            ws0_n_q <= sel_n[SW-1:0];
        end
    end

    // One record per edge; held a full link period, far longer than the sync
    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            cmd_q     <= '0;
            cmd_tog_q <= TOG_RST;
        end else if (wr_pend_q || cmd_new) begin
            cmd_q.rd_en   <= cmd_new && access_dir_read;
            cmd_q.rd_addr <= ADDR_MAX_W'(addr_i);
            cmd_q.wr_en   <= wr_pend_q;
            cmd_q.wr_addr <= ADDR_MAX_W'(wr_addr_q);
            cmd_q.d0      <= DATA_MAX_W'(wd0_n_q);
            cmd_q.d1      <= DATA_MAX_W'(dq_i);
            cmd_q.s0_n    <= pad_sel(ws0_n_q);
            cmd_q.s1_n    <= pad_sel(sel_n[SW-1:0]);
            cmd_tog_q     <= !cmd_tog_q;
        end
    end

    // System side: memory core
    logic [DW-1:0]     mem_even [2**AW];
    logic [DW-1:0]     mem_odd  [2**AW];
    logic [SYNC_W-1:0] ct_s;
    logic              cmd_evt;
    logic              rd_wait_q;
    logic [AW-1:0]     rd_addr_q;
    logic              res_tog_q;
    dbs_burst_type     res_q;
    logic [1:0]        ack_s;
    logic              res_busy;
    logic              ack_tog_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            ct_s  <= '0;
            ack_s <= '0;
        end else begin
            ct_s  <= {ct_s[SYNC_W-2:0], cmd_tog_q};
            ack_s <= {ack_s[0], ack_tog_q};
        end
    end

    assign cmd_evt  = ct_s[2] ^ ct_s[1];
    assign res_busy = res_tog_q ^ ack_s[1];

    // Lane writes; a masked lane keeps its old contents
    always_ff @(posedge clk) begin
        if (cmd_evt && cmd_q.wr_en) begin
            for (int i = 0; i < SW; i++) begin
                if (!cmd_q.s0_n[i]) begin
                    mem_even[cmd_q.wr_addr[AW-1:0]][i*LW +: LW] <= cmd_q.d0[i*LW +: LW];
                end
                if (!cmd_q.s1_n[i]) begin
                    mem_odd[cmd_q.wr_addr[AW-1:0]][i*LW +: LW] <= cmd_q.d1[i*LW +: LW];
                end
            end
        end
    end

    // Read runs a cycle after the event so a same-edge write is seen
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_wait_q <= 1'b0;
            rd_addr_q <= '0;
        end else if (cmd_evt && cmd_q.rd_en) begin
            rd_wait_q <= 1'b1;
            rd_addr_q <= cmd_q.rd_addr[AW-1:0];
        end else if (!res_busy) begin
            rd_wait_q <= 1'b0;
        end
    end

    // Result held until the link side acknowledges it
    always_ff @(posedge clk) begin
        if (reset) begin
            res_q     <= '0;
            res_tog_q <= TOG_RST;
        end else if (rd_wait_q && !res_busy && !(cmd_evt && cmd_q.rd_en)) begin
            res_q.w0  <= DATA_MAX_W'(mem_even[rd_addr_q]);
            res_q.w1  <= DATA_MAX_W'(mem_odd[rd_addr_q]);
            res_tog_q <= !res_tog_q;
        end
    end

    // Link side: result arrival and two-entry buffer
    logic [SYNC_W-1:0] rt_s;
    logic              res_pend_q;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic              push;
    logic              pop;
    dbs_fill_type      fill_q;
    dbs_burst_type     ent0_q;
    dbs_burst_type     ent1_q;

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            rt_s <= '0;
        end else begin
            rt_s <= {rt_s[SYNC_W-2:0], res_tog_q};
        end
    end

    // Arrival wins over a same-edge push
    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            res_pend_q <= 1'b0;
        end else if (rt_s[2] ^ rt_s[1]) begin
            res_pend_q <= 1'b1;
        end else if (push) begin
            res_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            ack_tog_q <= TOG_RST;
        end else if (push) begin
            ack_tog_q <= !ack_tog_q;
        end
    end

    assign buf_in_ready  = (fill_q != BUF_TWO);
    assign buf_out_valid = (fill_q != BUF_EMPTY);
    // Bus turnaround: no read burst over incoming write words
    assign buf_out_ready = load_strobe_n || access_dir_read;
    assign push          = res_pend_q && buf_in_ready;
    assign pop           = buf_out_valid && buf_out_ready;

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            fill_q <= BUF_EMPTY;
        end else begin
            case (fill_q)
                BUF_EMPTY: begin
                    if (push) begin
                        fill_q <= BUF_ONE;
                    end
                end
                BUF_ONE: begin
                    if (push && !pop) begin
                        fill_q <= BUF_TWO;
                    end else if (pop && !push) begin
                        fill_q <= BUF_EMPTY;
                    end
                end
                BUF_TWO: begin
                    if (pop) begin
                        fill_q <= BUF_ONE;
                    end
                end
                default: begin
                    fill_q <= BUF_EMPTY;
                end
            endcase
        end
    end

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            ent0_q <= '0;
            ent1_q <= '0;
        end else begin
            if (pop) begin
                ent0_q <= (push && fill_q == BUF_ONE) ? res_q : ent1_q;
            end else if (push && fill_q == BUF_EMPTY) begin
                ent0_q <= res_q;
            end
            if (push && (fill_q == BUF_TWO || (fill_q == BUF_ONE && !pop))) begin
                ent1_q <= res_q;
            end
        end
    end

    // Output launch: first word at the positive edge, second at the negative
    logic [DW-1:0] out_w0_q;
    logic [DW-1:0] out_w1_q;
    logic [DW-1:0] out_w1_n_q;
    logic          out_act_q;
    logic          out_act_n_q;
    logic          drive;

    always_ff @(posedge k_clk) begin
        if (rst_k_q) begin
            out_act_q <= 1'b0;
            out_w0_q  <= '0;
            out_w1_q  <= '0;
        end else begin
            out_act_q <= pop;
            if (pop) begin
                out_w0_q <= ent0_q.w0[DW-1:0];
                out_w1_q <= ent0_q.w1[DW-1:0];
            end
        end
    end

    always_ff @(negedge k_clk) begin
        if (rst_k_q) begin
            out_act_n_q <= 1'b0;
            out_w1_n_q  <= '0;
        end else begin
            out_act_n_q <= out_act_q;
            out_w1_n_q  <= out_w1_q;
        end
    end

    // Clock-phase mux stands in for a double-rate output cell
    assign drive           = k_clk ? out_act_q : out_act_n_q;
    assign dq_o            = k_clk ? out_w0_q : out_w1_n_q;
    assign dq_oe_n         = {DW{!drive}};
    assign read_valid_flag = drive;
    assign echo_timing_pair = {!k_clk, k_clk};

    addr_take_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        !load_strobe_n |=> wr_addr_q == $past(addr_i))
        else $error("address not captured on load");

    addr_ignore_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        load_strobe_n |=> $stable(wr_addr_q))
        else $error("address moved while deselected");

    dir_decode_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        !load_strobe_n |=> cmd_q.rd_en == $past(access_dir_read) && wr_pend_q == !$past(access_dir_read))
        else $error("direction decoded wrongly");

    load_idle_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        (load_strobe_n && !wr_pend_q) |=> $stable(cmd_tog_q))
        else $error("idle cycle started a transaction");

    write_word_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        (!load_strobe_n && !access_dir_read) ##1 1'b1 |=> cmd_q.wr_en && cmd_q.d1 == DATA_MAX_W'($past(dq_i)))
        else $error("second write word not taken");

    read_launch_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        pop |=> out_act_q && out_w0_q == $past(ent0_q.w0[DW-1:0]) && out_w1_q == $past(ent0_q.w1[DW-1:0]))
        else $error("read burst not launched");

    float_idle_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        (!out_act_q && !out_act_n_q) |-> (&dq_oe_n) && !read_valid_flag)
        else $error("data pins driven without a read");

    burst_pair_a: assert property (@(negedge k_clk) disable iff (rst_k_q)
        out_act_q |=> out_act_n_q && out_w1_n_q == $past(out_w1_q))
        else $error("second read word missing");

    first_word_a: assert property (@(negedge k_clk) disable iff (rst_k_q)
        wr_pend_q |=> wd0_n_q == $past(dq_i))
        else $error("first write word not taken");

    cmd_start_a: assert property (@(posedge k_clk) disable iff (rst_k_q)
        !load_strobe_n |=> cmd_tog_q != $past(cmd_tog_q))
        else $error("load did not start a transaction");

    lane_keep_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_evt && cmd_q.wr_en && cmd_q.s0_n[0]) |=>
            mem_even[cmd_q.wr_addr[AW-1:0]][LW-1:0] == $past(mem_even[cmd_q.wr_addr[AW-1:0]][LW-1:0]))
        else $error("masked lane overwritten");
endmodule
`default_nettype wire

// ### dbs_pkg.sv
// Shared constants and carriers for the burst-of-two double-rate RAM port
`default_nettype none
package dbs_pkg;
    localparam int DATA_MAX_W = 36;
    localparam int ADDR_MAX_W = 21;
    localparam int SEL_MAX_W  = 4;
    localparam int NIB_W      = 4;
    localparam int LANE9_W    = 9;
    localparam int NIB_SEL_W  = 2;
    localparam int ECHO_W     = 2;
    localparam int SYNC_W     = 3;
    localparam logic SYNC_RST = 1'b1;
    localparam logic TOG_RST  = 1'b0;

    typedef struct packed {
        logic                  rd_en;
        logic                  wr_en;
        logic [ADDR_MAX_W-1:0] rd_addr;
        logic [ADDR_MAX_W-1:0] wr_addr;
        logic [DATA_MAX_W-1:0] d0;
        logic [DATA_MAX_W-1:0] d1;
        logic [SEL_MAX_W-1:0]  s0_n;
        logic [SEL_MAX_W-1:0]  s1_n;
    } dbs_cmd_type;

    typedef struct packed {
        logic [DATA_MAX_W-1:0] w0;
        logic [DATA_MAX_W-1:0] w1;
    } dbs_burst_type;

    typedef enum logic [2:0] {
        BUF_EMPTY = 3'b001,
        BUF_ONE   = 3'b010,
        BUF_TWO   = 3'b100
    } dbs_fill_type;
endpackage
`default_nettype wire

// ### dbs_ctl_model.sv
// Behavioural model of the memory controller that drives the link pins
`timescale 1ns/10ps
`default_nettype none
module dbs_ctl_model
    import dbs_pkg::*;
#(
    parameter int DW = 36,
    parameter int AW = 4
) (
    input  wire logic                 k_clk,
    output logic                      load_strobe_n,
    output logic                      access_dir_read,
    output logic      [AW-1:0]        addr_o,
    output logic      [DW-1:0]        dq_drv,
    output logic                      dq_drv_en,
    output logic      [SEL_MAX_W-1:0] lane_sel_n,
    input  wire logic [DW-1:0]        dq_bus,
    input  wire logic                 read_valid_flag
);
    // Quarter of the link period, keeps every change clear of both edges
    localparam time QTR = 31;

    initial begin
        load_strobe_n = 1'b1;
        access_dir_read = 1'b0;
        addr_o = '0;
        dq_drv = '0;
        dq_drv_en = 1'b0;
        lane_sel_n = '1;
    end

    task automatic command(input logic rd, input logic [AW-1:0] a);
        @(negedge k_clk);
        #QTR;
        load_strobe_n = 1'b0;
        access_dir_read = rd;
        addr_o = a;
        @(posedge k_clk);
        #QTR;
        load_strobe_n = 1'b1;
        addr_o = ~a;
    endtask

    task automatic write_burst(input logic [AW-1:0] a, input dbs_burst_type d, input logic [7:0] sel_n);
        command(1'b0, a);
        dq_drv = d.w0[DW-1:0];
        lane_sel_n = sel_n[3:0];
        dq_drv_en = 1'b1;
        @(negedge k_clk);
        #QTR;
        dq_drv = d.w1[DW-1:0];
        lane_sel_n = sel_n[7:4];
        @(posedge k_clk);
        #QTR;
        dq_drv_en = 1'b0;
        lane_sel_n = ~lane_sel_n;
    endtask

    task automatic read_burst(input logic [AW-1:0] a, output dbs_burst_type q, output logic ok);
        q = '0;
        ok = 1'b0;
        command(1'b1, a);
        for (int n = 0; n < 24 && !ok; n++) begin
            @(posedge k_clk);
            #QTR;
            if (read_valid_flag === 1'b1) begin
                ok = 1'b1;
                q.w0[DW-1:0] = dq_bus;
                @(negedge k_clk);
                #QTR;
                q.w1[DW-1:0] = dq_bus;
            end
        end
    endtask

    // Garbage on every pin with load high; nothing may start
    task automatic idle_wiggle(input int n, output int vld_seen);
        vld_seen = 0;
        repeat (n) begin
            @(posedge k_clk);
            #QTR;
            addr_o = addr_o + 1'b1;
            access_dir_read = ~access_dir_read;
            dq_drv = ~dq_drv;
            dq_drv_en = 1'b1;
            lane_sel_n = '0;
            if (read_valid_flag === 1'b1) vld_seen++;
        end
        dq_drv_en = 1'b0;
        lane_sel_n = '1;
    endtask
endmodule
`default_nettype wire

// ### dbs_port_tb.sv
// Self-checking testbench for the double-rate burst RAM port
`timescale 1ns/10ps
`default_nettype none
module dbs_port_tb;
    import dbs_pkg::*;
    localparam int DW = 36;
    localparam int AW = 4;

    logic                 clk = 1'b0;
    logic                 k_clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 load_strobe_n;
    logic                 access_dir_read;
    logic [AW-1:0]        addr;
    logic [DW-1:0]        ctl_dq;
    logic                 ctl_en;
    logic [SEL_MAX_W-1:0] lane_sel_n;
    wire  [DW-1:0]        dq_bus;
    logic [DW-1:0]        dq_o;
    logic [DW-1:0]        dq_oe_n;
    logic                 read_valid_flag;
    logic [ECHO_W-1:0]    echo_timing_pair;
    int                   failures = 0;
    int                   tests_run = 0;

    always #2.5 clk = ~clk;
    initial begin
        #17;
        forever #62.5 k_clk = ~k_clk;
    end

    // Released lines show the inverse of the last driven word, never a stale match
    assign dq_bus = (dq_o & ~dq_oe_n) | ((ctl_en ? ctl_dq : ~ctl_dq) & dq_oe_n);

    dbs_port #(.DW(DW), .AW(AW)) uut (
        .clk(clk), .reset(reset), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
        .access_dir_read(access_dir_read), .addr_i(addr), .dq_i(dq_bus), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .nibble_write_select_n(2'b11), .byte_write_select_n(lane_sel_n),
        .read_valid_flag(read_valid_flag), .echo_timing_pair(echo_timing_pair)
    );

    dbs_ctl_model #(.DW(DW), .AW(AW)) ctl (
        .k_clk(k_clk), .load_strobe_n(load_strobe_n), .access_dir_read(access_dir_read),
        .addr_o(addr), .dq_drv(ctl_dq), .dq_drv_en(ctl_en), .lane_sel_n(lane_sel_n),
        .dq_bus(dq_bus), .read_valid_flag(read_valid_flag)
    );

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n, input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) if (!s[i]) merge[9*i +: 9] = n[9*i +: 9];
    endfunction

    task automatic do_read(input logic [AW-1:0] a, input dbs_burst_type e);
        dbs_burst_type q;
        logic          ok;
        ctl.read_burst(a, q, ok);
        check(DW'(ok), DW'(1'b1));
        check(q.w0[DW-1:0], e.w0[DW-1:0]);
        check(q.w1[DW-1:0], e.w1[DW-1:0]);
        check(DW'(read_valid_flag), DW'(1'b1));
        check(dq_oe_n, '0);
        @(posedge k_clk);
        #31;
        check(DW'(read_valid_flag), '0);
        check(dq_oe_n, '1);
    endtask

    task automatic t_idle();
        @(posedge k_clk);
        #31;
        check(DW'(echo_timing_pair), DW'(2'b01));
        check(dq_oe_n, '1);
        @(negedge k_clk);
        #31;
        check(DW'(echo_timing_pair), DW'(2'b10));
        $display("test idle done");
    endtask

    task automatic t_b2b();
        dbs_burst_type a = {36'h123456789, 36'hFEDCBA987};
        dbs_burst_type b = {36'h0F0F0F0F0, 36'h3C3C3C3C3};
        // Write then read the same place at once: new data must be seen
        ctl.write_burst(4'h7, a, 8'h00);
        do_read(4'h7, a);
        ctl.write_burst(4'h8, b, 8'h00);
        ctl.write_burst(4'h9, a, 8'h00);
        do_read(4'h8, b);
        do_read(4'h9, a);
        $display("test back to back done");
    endtask

    task automatic t_lanes();
        dbs_burst_type p = {36'hAAAAAAAAA, 36'h555555555};
        dbs_burst_type n = {36'h123456789, 36'h9ABCDEF01};
        dbs_burst_type e;
        ctl.write_burst(4'h5, p, 8'h00);
        ctl.write_burst(4'h5, n, {4'b1010, 4'b0101});
        e.w0 = merge(p.w0, n.w0, 4'b0101);
        e.w1 = merge(p.w1, n.w1, 4'b1010);
        do_read(4'h5, e);
        $display("test lanes done");
    endtask

    task automatic t_quiet();
        dbs_burst_type p = {36'h0DEADBEEF, 36'h7BADF00D1};
        int            seen;
        ctl.write_burst(4'h2, p, 8'h00);
        ctl.idle_wiggle(12, seen);
        check(DW'(seen), '0);
        do_read(4'h2, p);
        $display("test quiet done");
    endtask

    initial begin
        #200000;
        failures++;
        conclude();
    end

    initial begin
        // Longer than five clk cycles: the link side needs several k edges
        repeat (5) @(posedge k_clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (4) @(posedge k_clk);
        t_idle();
        t_b2b();
        t_lanes();
        t_quiet();
        conclude();
    end
endmodule
`default_nettype wire
